/* File: hdl/cslrc_button.sv */
// Reset button debouncer and hold timer.
// Assumes the button level is synchronous to clk, high while pressed.
`timescale 1ns/1ps
`default_nettype none
module cslrc_button import cslrc_pkg::*; #(
	parameter int unsigned DEB_CYCLES = DEB_CYC,
	parameter longint unsigned HOLD_CYCLES = HOLD_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Button
	input wire logic btn_raw,
	// Results
	output logic pressed,
	output logic long_held,
	output logic rel_short,
	output logic rel_long
);
	logic [31:0] deb_cnt_q;
	logic [39:0] hold_cnt_q;
	logic pressed_q;
	logic long_q;
	logic short_q;
	logic longr_q;
	wire logic raw_diff = btn_raw != pressed_q;
	wire logic deb_done = deb_cnt_q >= 32'(DEB_CYCLES - 1);
	wire logic hold_done = hold_cnt_q >= 40'(HOLD_CYCLES - 1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			deb_cnt_q <= 32'h0;
			pressed_q <= 1'b0;
		end else if (!raw_diff) begin
			deb_cnt_q <= 32'h0;
		end else if (deb_done) begin
			deb_cnt_q <= 32'h0;
			pressed_q <= btn_raw;
		end else begin
			deb_cnt_q <= deb_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_cnt_q <= 40'h0;
			long_q <= 1'b0;
		end else if (!pressed_q) begin
			hold_cnt_q <= 40'h0;
			long_q <= 1'b0;
		end else if (hold_done) begin
			long_q <= 1'b1;
		end else begin
			hold_cnt_q <= hold_cnt_q + 40'h1;
		end
	end

	// Release is the debounced falling edge of the press
	wire logic release_now = pressed_q && raw_diff && deb_done;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			short_q <= 1'b0;
			longr_q <= 1'b0;
		end else begin
			short_q <= release_now && !long_q;
			longr_q <= release_now && long_q;
		end
	end

	assign pressed = pressed_q;
	assign long_held = long_q;
	assign rel_short = short_q;
	assign rel_long = longr_q;
endmodule : cslrc_button
`default_nettype wire

/* File: hdl/cslrc_pkg.sv */
// Package for the chassis status LED and reset-button controller.
// Assumes a single 200 MHz system clock.
package cslrc_pkg;
	localparam int unsigned CLK_MHZ = 200;
	// Hold threshold of the reset button, in seconds
	localparam int unsigned HOLD_S = 5;
	localparam longint unsigned HOLD_CYC = longint'(HOLD_S) * CLK_MHZ * 1000000;
	// Blink half period, in ms
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
	// Button debounce time, in ms
	localparam int unsigned DEB_MS = 20;
	localparam int unsigned DEB_CYC = DEB_MS * CLK_MHZ * 1000;
	// Blinks per firmware-corrupt group, and whole group length in half periods
	localparam logic [2:0] CORRUPT_BLINKS = 3'h3;
	localparam logic [3:0] GROUP_SLOTS = 4'hA;

	typedef enum logic [1:0] {
		CSLRC_FW_NORMAL = 2'h0,
		CSLRC_FW_BUSY = 2'h1,
		CSLRC_FW_CORRUPT = 2'h2
	} cslrc_fw_t;

	typedef enum logic [2:0] {
		CSLRC_WL_OFF = 3'h0,
		CSLRC_WL_POOR = 3'h1,
		CSLRC_WL_FAIR = 3'h2,
		CSLRC_WL_GOOD = 3'h3,
		CSLRC_WL_EXCELLENT = 3'h4,
		CSLRC_WL_SEARCH = 3'h5
	} cslrc_wl_t;

	typedef enum logic [1:0] {
		CSLRC_SPD_10 = 2'h0,
		CSLRC_SPD_100 = 2'h1,
		CSLRC_SPD_1000 = 2'h2
	} cslrc_spd_t;

	typedef struct packed {
		logic link_up;
		cslrc_spd_t speed;
		logic traffic;
	} cslrc_eth_t;

	// Two-colour speed lamp
	typedef struct packed {
		logic yellow;
		logic green;
	} cslrc_spd_led_t;

	localparam logic [3:0] WL_MASK_OFF = 4'h0;
	localparam logic [3:0] WL_MASK_POOR = 4'h1;
	localparam logic [3:0] WL_MASK_FAIR = 4'h3;
	localparam logic [3:0] WL_MASK_GOOD = 4'h7;
	localparam logic [3:0] WL_MASK_EXC = 4'hF;
endpackage : cslrc_pkg

/* File: hdl/cslrc_top.sv */
// Chassis status LED and reset-button controller top.
// Assumes all status inputs are synchronous levels from firmware.
// Operation
// - Status lamp on while booting, updating, restoring
// - Corrupt firmware: status lamp blinks three, repeats
// - Activity lamp on while any task runs
// - Poor signal: first strength lamp only
// - Fair signal: lamps one and two
// - Good: three lamps; excellent: all four
// - Wireless disabled: all strength lamps off
// - Searching: strength lamps blink in succession
// - Three-speed variant: gigabit lights speed yellow
// - Hundred megabit: yellow two-speed, green three-speed
// - Speed lamp off without link or ten
// - Variant selects two or three speeds
// - Short press: reboot keeping configuration
// - Held five seconds: status lamp lights
// - Long press release: factory-default reboot
// - Factory defaults: hostname, DHCP, empty comment, admin
`timescale 1ns/1ps
`default_nettype none
module cslrc_top import cslrc_pkg::*; #(
	parameter bit THREE_SPEED = 1'b1,
	parameter int unsigned BLINK_CYCLES = BLINK_CYC,
	parameter int unsigned DEB_CYCLES = DEB_CYC,
	parameter longint unsigned HOLD_CYCLES = HOLD_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Status sources
	input wire cslrc_fw_t fw_state,
	input wire logic task_running,
	input wire cslrc_wl_t wl_state,
	input wire cslrc_eth_t eth,
	input wire logic btn_raw,
	// Lamps
	output logic status_led,
	output logic active_led,
	output logic [3:0] wl_led,
	output cslrc_spd_led_t speed_led,
	output logic link_activity_led,
	// Reboot requests, one-cycle pulses
	output logic reboot_keep,
	output logic reboot_factory,
	output logic factory_restore
);
	////////////////////////////////////////////////////////////////////////
	// Blink time base
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic phase_q;
	logic [3:0] slot_q;
	logic [1:0] walk_q;

	wire logic tick_wrap = tick_cnt_q >= 32'(BLINK_CYCLES - 1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? 32'h0 : tick_cnt_q + 32'h1;
			tick_q <= tick_wrap;
		end
	end

	// Slot counter walks one blink group; walk_q steps the search chase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= 1'b0;
			slot_q <= 4'h0;
			walk_q <= 2'h0;
		end else if (tick_q) begin
			phase_q <= ~phase_q;
			slot_q <= (slot_q == GROUP_SLOTS - 4'h1) ? 4'h0 : slot_q + 4'h1;
			walk_q <= walk_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Button
	logic long_held;
	logic rel_short;
	logic rel_long;

	cslrc_button #(
		.DEB_CYCLES(DEB_CYCLES),
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_button (
		.clk(clk),
		.arst_n(arst_n),
		.btn_raw(btn_raw),
		.pressed(),
		.long_held(long_held),
		.rel_short(rel_short),
		.rel_long(rel_long)
	);

	////////////////////////////////////////////////////////////////////////
	// Lamp decode
	function automatic logic [3:0] wl_mask(input cslrc_wl_t s, input logic [1:0] w);
		logic [3:0] m;
		m = WL_MASK_OFF;
		unique case (s)
			CSLRC_WL_POOR: m = WL_MASK_POOR;
			CSLRC_WL_FAIR: m = WL_MASK_FAIR;
			CSLRC_WL_GOOD: m = WL_MASK_GOOD;
			CSLRC_WL_EXCELLENT: m = WL_MASK_EXC;
			CSLRC_WL_SEARCH: m = 4'h1 << w;
			default: m = WL_MASK_OFF;
		endcase
		return m;
	endfunction : wl_mask

	// Odd slots below six give three lit half periods, then a dark gap
	wire logic corrupt_on = slot_q[0] && (slot_q < {CORRUPT_BLINKS, 1'b0});
	wire logic status_d = long_held
		|| (fw_state == CSLRC_FW_BUSY)
		|| ((fw_state == CSLRC_FW_CORRUPT) && corrupt_on);
	wire logic spd_1000 = eth.link_up && (eth.speed == CSLRC_SPD_1000) && THREE_SPEED;
	wire logic spd_100 = eth.link_up && (eth.speed == CSLRC_SPD_100);
	wire cslrc_spd_led_t speed_d = '{
		yellow: spd_1000 || (spd_100 && !THREE_SPEED),
		green: spd_100 && THREE_SPEED
	};
	wire logic link_d = eth.link_up && !(eth.traffic && phase_q);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_led <= 1'b0;
			active_led <= 1'b0;
			wl_led <= 4'h0;
			speed_led <= '0;
			link_activity_led <= 1'b0;
		end else begin
			status_led <= status_d;
			active_led <= task_running;
			wl_led <= wl_mask(wl_state, walk_q);
			speed_led <= speed_d;
			link_activity_led <= link_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reboot requests; firmware applies the factory settings on factory_restore
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reboot_keep <= 1'b0;
			reboot_factory <= 1'b0;
			factory_restore <= 1'b0;
		end else begin
			reboot_keep <= rel_short;
			reboot_factory <= rel_long;
			factory_restore <= rel_long;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_ACTIVE: assert property (@(posedge clk) disable iff (!arst_n)
		task_running |=> active_led) else $error("activity lamp missed task");
	AST_POOR: assert property (@(posedge clk) disable iff (!arst_n)
		wl_state == CSLRC_WL_POOR |=> wl_led == 4'h1) else $error("poor pattern wrong");
	AST_FAIR: assert property (@(posedge clk) disable iff (!arst_n)
		wl_state == CSLRC_WL_FAIR |=> wl_led == 4'h3) else $error("fair pattern wrong");
	AST_EXC: assert property (@(posedge clk) disable iff (!arst_n)
		wl_state == CSLRC_WL_EXCELLENT |=> wl_led == 4'hF) else $error("excellent wrong");
	AST_WLOFF: assert property (@(posedge clk) disable iff (!arst_n)
		wl_state == CSLRC_WL_OFF |=> wl_led == 4'h0) else $error("disabled lamps lit");
	AST_SEARCH: assert property (@(posedge clk) disable iff (!arst_n)
		wl_state == CSLRC_WL_SEARCH |=> $countones(wl_led) == 1) else $error("chase wrong");
	AST_SPD_OFF: assert property (@(posedge clk) disable iff (!arst_n)
		!eth.link_up |=> speed_led == '0) else $error("speed lamp lit without link");
	AST_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
		fw_state == CSLRC_FW_BUSY |=> status_led) else $error("status lamp dark while busy");
	AST_LONG: assert property (@(posedge clk) disable iff (!arst_n)
		long_held |=> status_led) else $error("status lamp dark on long hold");
	AST_EXCL: assert property (@(posedge clk) disable iff (!arst_n)
		!(reboot_keep && reboot_factory)) else $error("both reboot kinds");
	AST_GOOD: assert property (@(posedge clk) disable iff (!arst_n)
		wl_state == CSLRC_WL_GOOD |=> wl_led == 4'h7) else $error("good pattern wrong");
	AST_GAP: assert property (@(posedge clk) disable iff (!arst_n)
		(fw_state == CSLRC_FW_CORRUPT) && !long_held && (slot_q >= {CORRUPT_BLINKS, 1'b0})
		|=> !status_led) else $error("corrupt group gap lit");
	AST_SPD_1000: assert property (@(posedge clk) disable iff (!arst_n)
		eth.link_up && (eth.speed == CSLRC_SPD_1000) && THREE_SPEED
		|=> speed_led.yellow && !speed_led.green) else $error("gigabit lamp wrong");
	AST_SPD_100: assert property (@(posedge clk) disable iff (!arst_n)
		eth.link_up && (eth.speed == CSLRC_SPD_100)
		|=> (speed_led.green == THREE_SPEED) && (speed_led.yellow == !THREE_SPEED))
		else $error("hundred megabit lamp wrong");
	AST_LINK_OFF: assert property (@(posedge clk) disable iff (!arst_n)
		!eth.link_up |=> !link_activity_led) else $error("link lamp lit without link");
	AST_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
		reboot_factory |=> !reboot_factory && !reboot_keep) else $error("reboot pulse too long");
	AST_PAIR: assert property (@(posedge clk) disable iff (!arst_n)
		reboot_factory == factory_restore) else $error("restore not paired with reboot");
endmodule : cslrc_top
`default_nettype wire

/* File: sim/cslrc_btn_model.sv */
// Front-panel reset pushbutton model with contact chatter.
// Assumes press and bounce come from the bench clock domain.
`timescale 1ns/1ps
`default_nettype none
module cslrc_btn_model (
	// Clock
	input wire logic clk,
	// Control
	input wire logic press,
	input wire logic bounce,
	// Contact
	output logic btn_raw
);
	initial btn_raw = 1'b0;
	// Chatter flips every cycle, so it is never stable long enough to count
	always @(posedge clk) begin
		btn_raw <= bounce ? ~btn_raw : press;
	end
endmodule : cslrc_btn_model
`default_nettype wire

/* File: sim/cslrc_top_tb.sv */
// Self-checking bench for the status lamp and reset-button controller.
// Assumes short timing parameters; expectations derive from them.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %0h got %0h", nm, e, g); end end
module cslrc_top_tb import cslrc_pkg::*;;
	localparam int DEB = 3;
	localparam int HLD = 50;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	cslrc_fw_t fw_state = CSLRC_FW_NORMAL;
	logic task_running = 1'b0;
	cslrc_wl_t wl_state = CSLRC_WL_OFF;
	cslrc_eth_t eth = '0;
	logic press = 1'b0;
	logic bounce = 1'b0;
	logic btn_raw, status_led, active_led, link_led, keep, fact, rest;
	logic [3:0] wl_led;
	cslrc_spd_led_t speed_led, speed2_led;
	int error_cnt = 0;
	int n_tests = 0;
	int n_keep, n_fact, n_rest;
	////////////////////////////////////////////////////////////////////////
	cslrc_btn_model BTN (.clk(clk), .press(press), .bounce(bounce), .btn_raw(btn_raw));
	cslrc_top #(.THREE_SPEED(1'b1), .BLINK_CYCLES(4), .DEB_CYCLES(DEB), .HOLD_CYCLES(HLD)) DUT (
		.clk(clk), .arst_n(arst_n), .fw_state(fw_state), .task_running(task_running),
		.wl_state(wl_state), .eth(eth), .btn_raw(btn_raw), .status_led(status_led),
		.active_led(active_led), .wl_led(wl_led), .speed_led(speed_led),
		.link_activity_led(link_led), .reboot_keep(keep), .reboot_factory(fact),
		.factory_restore(rest));
	// Two-speed variant, only its speed lamp is watched
	cslrc_top #(.THREE_SPEED(1'b0), .BLINK_CYCLES(4), .DEB_CYCLES(DEB), .HOLD_CYCLES(HLD)) DUT2 (
		.clk(clk), .arst_n(arst_n), .fw_state(fw_state), .task_running(task_running),
		.wl_state(wl_state), .eth(eth), .btn_raw(btn_raw), .status_led(),
		.active_led(), .wl_led(), .speed_led(speed2_led), .link_activity_led(),
		.reboot_keep(), .reboot_factory(), .factory_restore());
	////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] exp_wl(cslrc_wl_t w);
		case (w)
			CSLRC_WL_POOR: return WL_MASK_POOR;
			CSLRC_WL_FAIR: return WL_MASK_FAIR;
			CSLRC_WL_GOOD: return WL_MASK_GOOD;
			CSLRC_WL_EXCELLENT: return WL_MASK_EXC;
			default: return WL_MASK_OFF;
		endcase
	endfunction : exp_wl
	function automatic cslrc_spd_led_t exp_spd(bit three, cslrc_eth_t e);
		exp_spd = '0;
		if (e.link_up && e.speed == CSLRC_SPD_100) exp_spd = three ? 2'h1 : 2'h2;
		if (e.link_up && e.speed == CSLRC_SPD_1000 && three) exp_spd = 2'h2;
	endfunction : exp_spd
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : wt
	task automatic final_report();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (keep === 1'b1) n_keep++;
		if (fact === 1'b1) n_fact++;
		if (rest === 1'b1) n_rest++;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("ERROR watchdog exp done got hang");
		final_report();
	end
	initial begin
		cslrc_eth_t e;
		cslrc_wl_t w;
		logic f, t, p;
		logic [3:0] seen;
		int rises, lit;
		void'($urandom(32'hEBF8FE9D));
		wt(8);
		`CHK("rst", 10'h0, {status_led, active_led, wl_led, speed_led, link_led, keep})
		@(posedge clk) arst_n <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			e = '{1'($urandom), cslrc_spd_t'(i < 3 ? i : $urandom % 3), 1'b0};
			w = cslrc_wl_t'(i < 5 ? i : $urandom % 5);
			f = 1'($urandom);
			t = 1'($urandom);
			@(posedge clk);
			eth <= e;
			wl_state <= w;
			task_running <= t;
			fw_state <= f ? CSLRC_FW_BUSY : CSLRC_FW_NORMAL;
			wt(2);
			`CHK("status", f, status_led)
			`CHK("active", t, active_led)
			`CHK("wl", exp_wl(w), wl_led)
			`CHK("speed", exp_spd(1'b1, e), speed_led)
			`CHK("speed2", exp_spd(1'b0, e), speed2_led)
			`CHK("link", e.link_up, link_led)
		end
		$display("test static done");
		@(posedge clk);
		wl_state <= CSLRC_WL_SEARCH;
		fw_state <= CSLRC_FW_CORRUPT;
		eth <= '{1'b1, CSLRC_SPD_100, 1'b1};
		wt(2);
		seen = 4'h0;
		rises = 0;
		lit = 0;
		p = status_led;
		// Two whole corrupt groups and ten traffic periods
		repeat (80) begin
			wt(1);
			`CHK("onehot", 1'b1, $onehot(wl_led))
			seen |= wl_led;
			rises += int'(status_led && !p);
			p = status_led;
			lit += int'(link_led);
		end
		`CHK("chase", 4'hF, seen)
		`CHK("groups", 6, rises)
		`CHK("traffic", 40, lit)
		$display("test blink done");
		// Reset in mid-run while lamps are busy must darken everything at once
		@(posedge clk) arst_n <= 1'b0;
		wt(2);
		`CHK("rst_mid", 10'h0, {status_led, active_led, wl_led, speed_led, link_led, keep})
		@(posedge clk) arst_n <= 1'b1;
		@(posedge clk);
		wl_state <= CSLRC_WL_OFF;
		fw_state <= CSLRC_FW_NORMAL;
		eth <= '0;
		bounce <= 1'b1;
		press <= 1'b1;
		n_keep = 0;
		n_fact = 0;
		n_rest = 0;
		wt(20);
		bounce <= 1'b0;
		press <= 1'b0;
		wt(20);
		`CHK("chatter", 0, n_keep + n_fact)
		press <= 1'b1;
		wt(10);
		// Chatter inside a held press must not end it
		bounce <= 1'b1;
		wt(4);
		bounce <= 1'b0;
		wt(16);
		`CHK("bounce_keep", 0, n_keep + n_fact)
		`CHK("short_lamp", 1'b0, status_led)
		press <= 1'b0;
		wt(10);
		`CHK("keep", 1, n_keep)
		`CHK("no_fact", 0, n_fact)
		press <= 1'b1;
		wt(DEB + HLD + 5);
		`CHK("long_lamp", 1'b1, status_led)
		press <= 1'b0;
		wt(10);
		`CHK("fact", 1, n_fact)
		`CHK("restore", 1, n_rest)
		`CHK("keep_once", 1, n_keep)
		$display("test button done");
		final_report();
	end
endmodule : cslrc_top_tb
`default_nettype wire
